// [hdl/cbc_top.sv]
/*
  Cell balance controller: frames measurement and bleed slots, picks the
  highest cell, latches the choice per dwell period, applies timeout, charger
  and fault-timing suppression. Registers over Avalon-MM.
  Assumes cell voltages arrive in millivolts, synchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module cbc_top #(
  parameter int N_CELLS = 8,
  parameter int MS_DIV = cbc_pkg::MS_CYCLES,
  parameter int DWELL_MS = cbc_pkg::DWELL_MS,
  parameter int HOUR_MS = cbc_pkg::HOUR_MS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [N_CELLS*16-1:0] cell_mv,
  input wire logic charger_attached_flag,
  input wire logic ov_timing,
  input wire logic uv_timing,
  output logic [N_CELLS-1:0] bleed,
  output logic meas_active,
  output logic [N_CELLS*16-1:0] cell_meas
);
  // ==========================================================
  // Highest cell; strict compare keeps the lowest index on a tie
  function automatic logic [7:0] pick_max(input logic [N_CELLS*16-1:0] v);
    logic [7:0] idx;
    logic [15:0] best;
    idx = 8'h0;
    best = v[15:0];
    for (int i = 1; i < N_CELLS; i++) begin
      if (v[i*16 +: 16] > best) begin
        best = v[i*16 +: 16];
        idx = 8'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] clamp_dly(input logic [15:0] d);
    return (d < cbc_pkg::PROT_DLY_MIN) ? cbc_pkg::PROT_DLY_MIN : d;
  endfunction

  logic ms_tick;
  cbc_ms_tick #(.DIV(MS_DIV)) u_tick (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick(ms_tick)
  );

  // ==========================================================
  // Configuration registers
  logic [7:0] cfg;
  logic [15:0] ov_dly;
  logic [15:0] uv_dly;
  logic bus_ack;
  logic [3:0] thr_code;
  logic [1:0] tmo_sel;
  logic [1:0] en_mode;
  assign thr_code = cfg[cbc_pkg::CFG_THR_LSB +: 4];
  assign tmo_sel = cfg[cbc_pkg::CFG_TMO_LSB +: 2];
  assign en_mode = cfg[cbc_pkg::CFG_EN_LSB +: 2];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= cbc_pkg::CFG_RESET;
      ov_dly <= cbc_pkg::PROT_DLY_MIN;
      uv_dly <= cbc_pkg::PROT_DLY_MIN;
    end else if (avs_write && !bus_ack) begin
      if (avs_address == cbc_pkg::REG_CFG) begin
        cfg <= avs_writedata[7:0];
      end else if (avs_address == cbc_pkg::REG_PROT) begin
        ov_dly <= clamp_dly(avs_writedata[15:0]);
        uv_dly <= clamp_dly(avs_writedata[31:16]);
      end
    end
  end

  // ==========================================================
  // Frame: 50 ms measurement, then 200 ms bleed slot
  cbc_pkg::cbc_slot_e slot;
  logic [15:0] slot_ms;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      slot <= cbc_pkg::CBC_MEAS;
      slot_ms <= 16'h0;
    end else if (ms_tick) begin
      unique case (slot)
        cbc_pkg::CBC_MEAS: begin
          if (slot_ms == 16'(cbc_pkg::MEAS_MS - 1)) begin
            slot <= cbc_pkg::CBC_BAL;
            slot_ms <= 16'h0;
          end else begin
            slot_ms <= slot_ms + 16'h1;
          end
        end
        cbc_pkg::CBC_BAL: begin
          if (slot_ms == 16'(cbc_pkg::BAL_MS - 1)) begin
            slot <= cbc_pkg::CBC_MEAS;
            slot_ms <= 16'h0;
          end else begin
            slot_ms <= slot_ms + 16'h1;
          end
        end
        default: begin
          slot <= cbc_pkg::CBC_MEAS;
          slot_ms <= 16'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // Measurement snapshot, frozen while bleeding
  logic snap_valid;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cell_meas <= '0;
      snap_valid <= 1'b0;
    end else if (bleed == '0 && slot == cbc_pkg::CBC_MEAS) begin
      cell_meas <= cell_mv;
      snap_valid <= 1'b1;
    end
  end

  // ==========================================================
  // Threshold and candidate
  logic [15:0] thr_mv;
  logic [7:0] top_idx;
  logic above;
  assign thr_mv = 16'(cbc_pkg::THR_TOP_MV - 16'(thr_code * cbc_pkg::THR_STEP_MV));
  assign top_idx = pick_max(cell_meas);
  assign above = snap_valid && (cell_meas[top_idx*16 +: 16] > thr_mv);

  // ==========================================================
  // Balance timer, started by first crossing of the threshold
  logic tmr_run;
  logic tmo_expired;
  logic [31:0] tmr_ms;
  logic [31:0] tmo_ms;
  logic tmo_used;
  assign tmo_ms = 32'(HOUR_MS) << tmo_sel;
  // Timeout applies in the charger mode and the timed always mode
  assign tmo_used = (en_mode == cbc_pkg::EN_CHG) || (en_mode == cbc_pkg::EN_ALWAYS_TMO);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tmr_run <= 1'b0;
      tmr_ms <= 32'h0;
      tmo_expired <= 1'b0;
    end else if (!tmo_used || en_mode == cbc_pkg::EN_OFF) begin
      tmr_run <= 1'b0;
      tmr_ms <= 32'h0;
      tmo_expired <= 1'b0;
    end else if (!tmr_run && !tmo_expired && above) begin
      tmr_run <= 1'b1;
      tmr_ms <= 32'h0;
    end else if (tmr_run && ms_tick) begin
      if (tmr_ms >= tmo_ms - 32'h1) begin
        tmr_run <= 1'b0;
        tmo_expired <= 1'b1;
      end else begin
        tmr_ms <= tmr_ms + 32'h1;
      end
    end
  end

  // ==========================================================
  // Dwell period: choice latched once per period
  logic [31:0] dwell_ms;
  logic dwell_due;
  logic [7:0] choice_idx;
  logic choice_valid;
  assign dwell_due = (dwell_ms == 32'h0);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dwell_ms <= 32'h0;
      choice_idx <= 8'h0;
      choice_valid <= 1'b0;
    end else if (tmo_expired || en_mode == cbc_pkg::EN_OFF) begin
      dwell_ms <= 32'h0;
      choice_valid <= 1'b0;
    end else if (dwell_due && snap_valid) begin
      choice_idx <= top_idx;
      choice_valid <= above;
      // Full count of ticks, so latches sit one whole dwell period apart
      dwell_ms <= 32'(DWELL_MS);
    end else if (ms_tick && !dwell_due) begin
      dwell_ms <= dwell_ms - 32'h1;
    end
  end

  // ==========================================================
  // Suppression and bleed drive
  logic allow;
  always_comb begin
    allow = choice_valid && (slot == cbc_pkg::CBC_BAL);
    if (en_mode == cbc_pkg::EN_OFF) begin
      allow = 1'b0;
    end
    if (en_mode == cbc_pkg::EN_CHG && !charger_attached_flag) begin
      allow = 1'b0;
    end
    if (tmo_used && tmo_expired) begin
      allow = 1'b0;
    end
    // Fault timing only pauses; the latched choice survives it
    if (ov_timing || uv_timing) begin
      allow = 1'b0;
    end
  end

  // Charging never looks at bleed state, so both run together
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bleed <= '0;
      meas_active <= 1'b1;
    end else begin
      bleed <= allow ? (N_CELLS'(1) << choice_idx) : '0;
      meas_active <= (slot == cbc_pkg::CBC_MEAS);
    end
  end

  // ==========================================================
  // Avalon-MM: one wait cycle, then ack
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
      if (avs_read && !bus_ack) begin
        unique case (avs_address)
          cbc_pkg::REG_CFG: avs_readdata <= {24'h0, cfg};
          cbc_pkg::REG_PROT: avs_readdata <= {uv_dly, ov_dly};
          cbc_pkg::REG_STATUS: avs_readdata <= {8'h0, 8'(bleed), choice_idx,
            4'h0, meas_active, tmr_run, tmo_expired, choice_valid};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
endmodule
`default_nettype wire

// [hdl/cbc_pkg.sv]
/*
  Constants for the cell balance controller: timing counts, configuration field
  layout, threshold codes and state encodings.
  Assumes a single 200 MHz system clock and Avalon-MM register access.
*/
// Contract
// - Bleed choice is re-evaluated and latched once per dwell period of 7.5 minutes.
// - Bleed the highest cell only when it exceeds start threshold, no hysteresis.
// - Never bleed more than one cell at a time.
// - After timeout expiry the choice calculation is reset and inhibited.
// - With timeout configured, all bleeding stops once the balance timer expires.
// - Charge-only mode: no bleeding without charger, stop at once on disconnect.
// - 250 ms frame: 50 ms measurement with no bleed, then 200 ms bleed slot.
// - Measurement results stay frozen while any bleed output is asserted.
// - Overvoltage and undervoltage delay settings are never below 500 ms.
// - Bleeding is suspended while an OV or UV condition is being timed.
// - Balancing resumes once fault timing ends, cleared or latched.
// - A 2-bit timeout field selects 1, 2, 4 or 8 hours.
// - Balance timer starts when the first cell rises above the start threshold.
// - 4-bit start threshold, 3.9 V down to 2.4 V in 0.1 V steps, default 3.9 V.
// - Configuration selects balancing always, only with charger, or never.
// - Balance-enable field of zero disables balancing completely.
// - Balancing runs alongside charging without pausing it.
// - Charger-attached flag is asserted as long as a charger is connected.
package cbc_pkg;

  // ==========================================================
  // Clock and timing
  localparam longint CLK_HZ = 200_000_000;
  localparam int MEAS_MS = 50;
  localparam int BAL_MS = 200;
  localparam int FRAME_MS = 250;
  localparam int MS_CYCLES = int'(CLK_HZ / 1000);
  localparam real DWELL_MIN = 7.5;
  localparam int DWELL_MS = int'(DWELL_MIN * 60.0 * 1000.0);
  localparam int HOUR_MS = 3_600_000;
  localparam int MIN_PROT_DLY_MS = 500;
  localparam int OV_TIMING_MAX_MS = 2250;
  localparam int UV_TIMING_MAX_MS = 32000;

  // ==========================================================
  // Register map (byte offsets)
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_PROT = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // Configuration word fields
  localparam int CFG_THR_LSB = 0;
  localparam int CFG_TMO_LSB = 4;
  localparam int CFG_EN_LSB = 6;
  localparam logic [7:0] CFG_RESET = 8'h40;

  // Balance enable field codes
  localparam logic [1:0] EN_OFF = 2'h0;
  localparam logic [1:0] EN_CHG = 2'h1;
  localparam logic [1:0] EN_ALWAYS = 2'h2;
  localparam logic [1:0] EN_ALWAYS_TMO = 2'h3;

  // Protection delays in ms, 16 bits each
  localparam logic [15:0] PROT_DLY_MIN = 16'h01F4;

  // Threshold code 0 is 3.9 V; millivolts = TOP - code * STEP
  localparam logic [15:0] THR_TOP_MV = 16'h0F3C;
  localparam logic [15:0] THR_STEP_MV = 16'h0064;

  typedef enum logic [1:0] {
    CBC_MEAS = 2'b00,
    CBC_BAL = 2'b01
  } cbc_slot_e;

endpackage

// [hdl/cbc_ms_tick.sv]
/*
  Millisecond tick divider.
  Assumes the system clock and reset of the controller.
*/
`timescale 1ns/10ps
`default_nettype none
module cbc_ms_tick #(
  parameter int DIV = cbc_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  output logic tick
);
  logic [31:0] cnt;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else if (cnt == 32'(DIV - 1)) begin
      cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [sim/cbc_chk_props.sv]
/* Port checker for the balance controller, bound into cbc_top.
   Assumes one clock and the asynchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module cbc_chk #(
  parameter int N_CELLS = 8,
  parameter int MS_DIV = 10
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic charger_attached_flag,
  input wire logic ov_timing,
  input wire logic uv_timing,
  input wire logic [N_CELLS-1:0] bleed,
  input wire logic meas_active,
  input wire logic [N_CELLS*16-1:0] cell_meas
);
  localparam int MEAS_CYC = 50 * MS_DIV;
  localparam int BAL_CYC = 200 * MS_DIV;
  logic [1:0] mode;
  logic [15:0] run;
  logic seen;
  // ====================
  // Helpers
  // Mode is taken on the write's first edge, as the design does
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode <= cbc_pkg::CFG_RESET[7:6];
    end else if (avs_write && avs_waitrequest && avs_address == cbc_pkg::REG_CFG) begin
      mode <= avs_writedata[7:6];
    end
  end
  // First two slots after reset are skipped: the first does not start on a frame edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run <= 16'h0000;
      seen <= 1'h0;
    end else begin
      run <= $changed(meas_active) ? 16'h0001 : run + 16'h0001;
      seen <= seen | $rose(meas_active);
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  property p_one; $onehot0(bleed); endproperty
  a_one: assert property (p_one) else $error("two cells bled");
  property p_meas; meas_active |-> bleed == '0; endproperty
  a_meas: assert property (p_meas) else $error("bleed in measure slot");
  property p_frz; (|bleed) |=> $stable(cell_meas); endproperty
  a_frz: assert property (p_frz) else $error("snapshot moved");
  property p_flt; (ov_timing || uv_timing) |=> bleed == '0; endproperty
  a_flt: assert property (p_flt) else $error("bleed in fault timing");
  property p_chg; mode == cbc_pkg::EN_CHG && !charger_attached_flag |=> bleed == '0; endproperty
  a_chg: assert property (p_chg) else $error("bleed without charger");
  property p_off; mode == cbc_pkg::EN_OFF |=> bleed == '0; endproperty
  a_off: assert property (p_off) else $error("bleed while off");
  property p_mlen; $fell(meas_active) && seen |-> run == MEAS_CYC; endproperty
  a_mlen: assert property (p_mlen) else $error("measure slot length");
  property p_blen; $rose(meas_active) && seen |-> run == BAL_CYC; endproperty
  a_blen: assert property (p_blen) else $error("bleed slot length");
  c_bleed: cover property ((|bleed) && charger_attached_flag);
  c_flt: cover property ($past(|bleed) && uv_timing);
  c_frame: cover property ($rose(meas_active) && seen);
endmodule
bind cbc_top cbc_chk #(.N_CELLS(N_CELLS), .MS_DIV(MS_DIV)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .charger_attached_flag(charger_attached_flag), .ov_timing(ov_timing),
  .uv_timing(uv_timing), .bleed(bleed), .meas_active(meas_active), .cell_meas(cell_meas)
);
`default_nettype wire

// [sim/cbc_pack.sv]
/* Behavioural cell stack and charger for the balance controller bench.
   Assumes the bench sets the open-circuit voltages and the plug. */
`timescale 1ns/10ps
`default_nettype none
module cbc_pack #(
  parameter int N_CELLS = 8
) (
  input wire logic [N_CELLS*16-1:0] set_mv,
  input wire logic plug,
  input wire logic [N_CELLS-1:0] bleed,
  output logic [N_CELLS*16-1:0] cell_mv,
  output logic charger_attached_flag
);
  // Bleed current sags the reading by 50 mV, so a snapshot taken
  // while bleeding would steer the next choice away
  for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
    assign cell_mv[16*i+:16] = set_mv[16*i+:16] - (bleed[i] ? 16'h0032 : 16'h0000);
  end
  assign charger_attached_flag = plug;
endmodule
`default_nettype wire

// [sim/cbc_top_tb_top.sv]
/* Bench for cbc_top: registers, cell choice, modes, faults, timeout.
   Assumes cbc_pack stands for the cell stack and charger. */
`timescale 1ns/10ps
`default_nettype none
module cbc_top_tb_top;
  localparam int MSD = 5;
  localparam int DW = 20;
  localparam int HR = 400;
  logic clk_sys, arst_n, rd, wr, plug, ov, uv, meas, wreq, flag;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [127:0] set_mv, cmv;
  logic [7:0] bleed;
  int num_errors = 0;
  int tests_run = 0;
  int last, lim;
  cbc_top #(.N_CELLS(8), .MS_DIV(MSD), .DWELL_MS(DW), .HOUR_MS(HR)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq), .cell_mv(cmv),
    .charger_attached_flag(flag), .ov_timing(ov), .uv_timing(uv), .bleed(bleed),
    .meas_active(meas), .cell_meas()
  );
  cbc_pack #(.N_CELLS(8)) u_pack (
    .set_mv(set_mv), .plug(plug), .bleed(bleed), .cell_mv(cmv), .charger_attached_flag(flag)
  );
  // ====================
  // Tasks
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wreq !== 1'h0 && n < 50);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
    @(posedge clk_sys);
  endtask
  task automatic wait_meas(input logic v);
    int n;
    n = 0;
    while (meas !== v) begin
      @(posedge clk_sys);
      n++;
      if (n > 2000) begin
        num_errors++;
        stop_test();
      end
    end
  endtask
  // A fresh snapshot plus two dwell periods lets the latched choice catch up
  task automatic pick(input logic [3:0] th, input logic [1:0] md, input logic [127:0] v,
    input logic [7:0] ex);
    set_mv <= v;
    acc(1'h1, cbc_pkg::REG_CFG, {24'h0, md, 2'h0, th});
    wait_meas(1'h1);
    wait_meas(1'h0);
    repeat (2 * DW * MSD + 10) @(posedge clk_sys);
    chk("bleed", {24'h0, bleed}, {24'h0, ex});
  endtask
  function automatic logic [127:0] cells(input int i, input logic [15:0] a, input int j,
    input logic [15:0] b);
    logic [127:0] v;
    v = {8{16'h0BB8}};
    v[16*j+:16] = b;
    v[16*i+:16] = a;
    return v;
  endfunction
  // ====================
  // Sequence
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    arst_n = 1'h0;
    {rd, wr, plug, ov, uv} = 5'h00;
    addr = 4'h0;
    wdata = 32'h0;
    set_mv = cells(0, 16'h0BB8, 0, 16'h0BB8);
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'h1;
    @(posedge clk_sys);
    acc(1'h0, cbc_pkg::REG_CFG, 32'h0);
    chk("cfg", q, {24'h0, cbc_pkg::CFG_RESET});
    acc(1'h1, cbc_pkg::REG_PROT, 32'h0064_0064);
    acc(1'h0, cbc_pkg::REG_PROT, 32'h0);
    chk("prot", q, 32'h01F4_01F4);
    acc(1'h0, 4'hC, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("regs done");
    pick(4'h0, cbc_pkg::EN_ALWAYS, cells(3, 16'h0FA0, 5, 16'h0FA0), 8'h08);
    pick(4'h0, cbc_pkg::EN_ALWAYS, cells(3, 16'h0F3C, 5, 16'h0F0A), 8'h00);
    pick(4'h5, cbc_pkg::EN_ALWAYS, cells(6, 16'h0D49, 1, 16'h0CE4), 8'h40);
    pick(4'hF, cbc_pkg::EN_ALWAYS, cells(7, 16'h0BB9, 0, 16'h0BB8), 8'h80);
    $display("choice done");
    pick(4'h0, cbc_pkg::EN_OFF, cells(2, 16'h0FA0, 2, 16'h0FA0), 8'h00);
    pick(4'h0, cbc_pkg::EN_CHG, cells(2, 16'h0FA0, 2, 16'h0FA0), 8'h00);
    plug <= 1'h1;
    // A mode without timeout clears the timer, so the next check starts a fresh one
    acc(1'h1, cbc_pkg::REG_CFG, {24'h0, cbc_pkg::EN_ALWAYS, 6'h00});
    pick(4'h0, cbc_pkg::EN_CHG, cells(2, 16'h0FA0, 2, 16'h0FA0), 8'h04);
    plug <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk("unplug", {24'h0, bleed}, 32'h0);
    pick(4'h0, cbc_pkg::EN_ALWAYS, cells(2, 16'h0FA0, 2, 16'h0FA0), 8'h04);
    for (int f = 0; f < 2; f++) begin
      ov <= (f == 0);
      uv <= (f == 1);
      repeat (3) @(posedge clk_sys);
      chk("fault", {24'h0, bleed}, 32'h0);
      ov <= 1'h0;
      uv <= 1'h0;
      repeat (3) @(posedge clk_sys);
      chk("resume", {24'h0, bleed}, 32'h4);
    end
    $display("modes done");
    for (int t = 0; t < 4; t++) begin
      pick(4'h0, cbc_pkg::EN_ALWAYS, cells(2, 16'h0BB8, 2, 16'h0BB8), 8'h00);
      acc(1'h1, cbc_pkg::REG_CFG, {24'h0, cbc_pkg::EN_ALWAYS_TMO, t[1:0], 4'h0});
      set_mv <= cells(2, 16'h0FA0, 2, 16'h0FA0);
      lim = (HR * MSD) << t;
      last = 0;
      for (int n = 0; n < lim + 1500; n++) begin
        @(posedge clk_sys);
        if (bleed !== 8'h00) last = n;
      end
      chk("tmo", {31'h0, last >= lim - 300 && last <= lim + 1400}, 32'h1);
    end
    acc(1'h0, cbc_pkg::REG_STATUS, 32'h0);
    chk("valid", {31'h0, q[0]}, 32'h0);
    chk("expired", {31'h0, q[1]}, 32'h1);
    $display("timeout done");
    stop_test();
  end
endmodule
`default_nettype wire
